// ### verilog/pcsi_pc_sequencer.sv
// Notes on behaviour
// - Program counter is 13 bits; its low byte is a readable, writable register.
// - Any reset clears the whole program counter to zero.
// - Upper five bits are never read or written directly, only from the latch.
// - Writing the low byte loads upper bits from latch bits 4..0 together.
// - Call or jump takes bits 10..0 from operand, 12..11 from latch 4..3.
// - Adding to the low byte wraps at 255 with no carry upward.
// - Eight-entry return stack of 13-bit words; its pointer is hidden.
// - Calls and interrupt vectoring push the program counter.
// - Return (PCSI_OP_RET, also used for interrupt exit) pops the stack.
// - Pushes and pops never change the upper latch.
// - Stack is circular; ninth push overwrites the first.
// - No overflow or underflow status is provided.
// - Indirect window has no storage; it reaches the pointed data location.
// - Reading the window through a self-pointing pointer yields zero.
// - Writing the window through a self-pointing pointer stores nothing.
// - Indirect address is bank bit over the 8-bit pointer, nine bits.
`timescale 1ns/1ps

module pcsi_pc_sequencer
    import pcsi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [WB_SEL_W-1:0] wb_sel_i,
    input wire logic [WB_DAT_W-1:0] wb_dat_i,
    output logic [WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pcsi_core_op_s core_op_i,
    output logic [PC_W-1:0] pc_o,
    output logic [DADDR_W-1:0] dmem_addr_o,
    output logic dmem_we_o,
    output logic [LOW_W-1:0] dmem_wdata_o,
    input wire logic [LOW_W-1:0] dmem_rdata_i
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [WB_ADR_W-1:0] adr, input logic [WB_ADR_W-1:0] off);
        reg_hit = (adr == off);
    endfunction : reg_hit

    function automatic logic [WB_DAT_W-1:0] byte_word(input logic [LOW_W-1:0] b);
        byte_word = {{(WB_DAT_W-LOW_W){1'b0}}, b};
    endfunction : byte_word

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [LATCH_W-1:0] latch_r;
    logic [LOW_W-1:0] pointer_r;
    logic bank_r;
    logic page_r;
    logic ack_r;
    logic [WB_DAT_W-1:0] rdata_r;
    logic [WB_DAT_W-1:0] rdata_nxt;
    pcsi_dmem_req_s dmem_r;

    // ----------------------------------------------------------------
    // Bus slave decode
    // ----------------------------------------------------------------
    // Request is registered; ack comes one cycle after strobe and
    // drops the cycle after, so write effects happen on the ack edge
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire bus_fire = wb_cyc_i & wb_stb_i & ack_r;
    wire lane_wr = wb_we_i & wb_sel_i[0];
    wire hit_low = reg_hit(wb_adr_i, OFF_PC_LOW);
    wire hit_latch = reg_hit(wb_adr_i, OFF_UPPER_LATCH);
    wire hit_pointer = reg_hit(wb_adr_i, OFF_POINTER);
    wire hit_status = reg_hit(wb_adr_i, OFF_STATUS);
    wire hit_window = reg_hit(wb_adr_i, OFF_WINDOW);
    wire hit_view = reg_hit(wb_adr_i, OFF_PC_VIEW);
    wire wr_low = bus_fire & lane_wr & hit_low;
    wire wr_latch = bus_fire & lane_wr & hit_latch;
    wire wr_pointer = bus_fire & lane_wr & hit_pointer;
    wire wr_status = bus_fire & lane_wr & hit_status;

    // ----------------------------------------------------------------
    // Indirect addressing
    // ----------------------------------------------------------------
    // Window is only a decode; the data lives in the data memory
    wire self_ref = (pointer_r == WINDOW_FILE_ADDR);
    wire [DADDR_W-1:0] ind_addr = {bank_r, pointer_r};
    wire win_wr_req = bus_req & lane_wr & hit_window & ~self_ref;
    wire [LOW_W-1:0] win_rd = self_ref ? WINDOW_SELF_READ : dmem_rdata_i;

    // ----------------------------------------------------------------
    // Program counter sequencing
    // ----------------------------------------------------------------
    wire op_active = (core_op_i.kind != PCSI_OP_NONE);
    wire do_push = (core_op_i.kind == PCSI_OP_CALL) | (core_op_i.kind == PCSI_OP_IRQ);
    wire do_pop = (core_op_i.kind == PCSI_OP_RET);
    wire [PC_W-1:0] pc_inc = pc_r + PC_ONE;
    wire [LOW_W-1:0] low_sum = pc_r[LOW_W-1:0] + core_op_i.addend;
    wire [PC_W-1:0] far_target = {latch_r[LATCH_PAGE_HI:LATCH_PAGE_LO], core_op_i.operand};
    wire [PC_W-1:0] push_data = (core_op_i.kind == PCSI_OP_CALL) ? pc_inc : pc_r;
    wire [PC_W-1:0] stack_top;

    always_comb begin
        pc_nxt = pc_r;
        case (core_op_i.kind)
            PCSI_OP_STEP: begin
                pc_nxt = pc_inc;
            end
            PCSI_OP_JUMP, PCSI_OP_CALL: begin
                pc_nxt = far_target;
            end
            PCSI_OP_RET: begin
                pc_nxt = stack_top;
            end
            PCSI_OP_IRQ: begin
                pc_nxt = IRQ_VECTOR;
            end
            PCSI_OP_ADD_LOW: begin
                pc_nxt = {pc_r[PC_W-1:LOW_W], low_sum};
            end
            default: begin
                // Any core op has priority; a bus low-byte write needs an idle core
                if (wr_low) begin
                    pc_nxt = {latch_r, wb_dat_i[LOW_W-1:0]};
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // Latch is touched by the bus only, never by stack traffic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_r <= LATCH_RESET;
        end else if (wr_latch) begin
            latch_r <= wb_dat_i[LATCH_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pointer_r <= BYTE_ZERO;
        end else if (wr_pointer) begin
            pointer_r <= wb_dat_i[LOW_W-1:0];
        end
    end

    // Both bits are stored as written; software keeps them clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_r <= 1'b0;
            page_r <= 1'b0;
        end else if (wr_status) begin
            bank_r <= wb_dat_i[STATUS_BANK_BIT];
            page_r <= wb_dat_i[STATUS_PAGE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    // No status output: overflow and underflow are silent
    pcsi_ret_stack i_pcsi_ret_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(do_push),
        .pop_i(do_pop),
        .din_i(push_data),
        .top_o(stack_top)
    );

    // ----------------------------------------------------------------
    // Read data and ack
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = WORD_ZERO;
        if (hit_low) begin
            rdata_nxt = byte_word(pc_r[LOW_W-1:0]);
        end else if (hit_latch) begin
            rdata_nxt = byte_word({{(LOW_W-LATCH_W){1'b0}}, latch_r});
        end else if (hit_pointer) begin
            rdata_nxt = byte_word(pointer_r);
        end else if (hit_status) begin
            rdata_nxt = byte_word({bank_r, page_r, {(LOW_W-2){1'b0}}});
        end else if (hit_window) begin
            rdata_nxt = byte_word(win_rd);
        end else if (hit_view) begin
            // Upper pc bits stay hidden; the view mirrors the low byte only
            rdata_nxt = byte_word(pc_r[LOW_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= WORD_ZERO;
        end else begin
            ack_r <= bus_req;
            if (bus_req) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Data write is issued in the request cycle so it lands on the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dmem_r <= '0;
        end else begin
            dmem_r.we <= win_wr_req;
            dmem_r.addr <= ind_addr;
            dmem_r.wdata <= wb_dat_i[LOW_W-1:0];
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign pc_o = pc_r;
    assign dmem_addr_o = dmem_r.we ? dmem_r.addr : ind_addr;
    assign dmem_we_o = dmem_r.we;
    assign dmem_wdata_o = dmem_r.wdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_reset_pc_clear: assert property (@(posedge clk_i)
        rst_i |=> pc_o == PC_RESET)
        else $error("pc not cleared by reset");

    a_low_write_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_low && !op_active) |=> pc_o == {$past(latch_r), $past(wb_dat_i[LOW_W-1:0])})
        else $error("low byte write did not load full pc");

    a_call_jump_target: assert property (@(posedge clk_i) disable iff (rst_i)
        (core_op_i.kind == PCSI_OP_CALL || core_op_i.kind == PCSI_OP_JUMP)
        |=> pc_o == {$past(latch_r[LATCH_PAGE_HI:LATCH_PAGE_LO]), $past(core_op_i.operand)})
        else $error("call or jump target wrong");

    a_add_low_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        core_op_i.kind == PCSI_OP_ADD_LOW
        |=> pc_o[PC_W-1:LOW_W] == $past(pc_o[PC_W-1:LOW_W])
            && pc_o[LOW_W-1:0] == LOW_W'($past(pc_o[LOW_W-1:0]) + $past(core_op_i.addend)))
        else $error("low byte add carried or miscomputed");

    a_latch_stack_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        ((do_push || do_pop) && !wr_latch) |=> $stable(latch_r))
        else $error("latch changed on stack operation");

    a_call_ret_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        (core_op_i.kind == PCSI_OP_CALL) ##1 (core_op_i.kind == PCSI_OP_RET)
        |=> pc_o == $past(pc_o, 2) + PC_ONE)
        else $error("return did not resume after call");

    a_window_self_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && hit_window && self_ref) |=> wb_ack_o && wb_dat_o == WORD_ZERO)
        else $error("self pointing window read not zero");

    a_window_no_store: assert property (@(posedge clk_i) disable iff (rst_i)
        dmem_we_o |-> $past(!self_ref) && dmem_addr_o == $past(ind_addr))
        else $error("window write stored through self pointer");

    a_indirect_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        !dmem_we_o |-> dmem_addr_o == {bank_r, pointer_r})
        else $error("indirect address not bank over pointer");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // ----------------------------------------------------------------
    // Further checks on sequencing and the bus side
    // ----------------------------------------------------------------
    a_reset_bus_idle: assert property (@(posedge clk_i)
        rst_i |=> !wb_ack_o && !dmem_we_o)
        else $error("bus outputs not idle after reset");

    a_step_increment: assert property (@(posedge clk_i) disable iff (rst_i)
        core_op_i.kind == PCSI_OP_STEP |=> pc_o == $past(pc_o) + PC_ONE)
        else $error("step did not advance pc by one");

    a_irq_vector_load: assert property (@(posedge clk_i) disable iff (rst_i)
        core_op_i.kind == PCSI_OP_IRQ |=> pc_o == IRQ_VECTOR)
        else $error("interrupt did not load the vector");

    a_ret_restore_top: assert property (@(posedge clk_i) disable iff (rst_i)
        do_pop |=> pc_o == $past(stack_top))
        else $error("return did not restore stack top");

    a_idle_pc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!op_active && !wr_low) |=> $stable(pc_o))
        else $error("pc changed without an op or low byte write");

    a_latch_bus_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_latch |=> latch_r == $past(wb_dat_i[LATCH_W-1:0]))
        else $error("latch write not stored");

    a_pointer_bus_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pointer |=> pointer_r == $past(wb_dat_i[LOW_W-1:0]))
        else $error("pointer write not stored");

    a_bank_bus_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_status |=> bank_r == $past(wb_dat_i[STATUS_BANK_BIT]))
        else $error("bank bit write not stored");

    a_ack_after_request: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");

    a_no_stray_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");

    a_low_byte_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && hit_low) |=> wb_dat_o == {{(WB_DAT_W-LOW_W){1'b0}}, $past(pc_o[LOW_W-1:0])})
        else $error("low byte read wrong");

    a_view_upper_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && hit_view) |=> wb_dat_o == {{(WB_DAT_W-LOW_W){1'b0}}, $past(pc_o[LOW_W-1:0])})
        else $error("pc view exposed upper bits");

    a_window_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && hit_window && !self_ref) |=> wb_dat_o == {{(WB_DAT_W-LOW_W){1'b0}}, $past(dmem_rdata_i)})
        else $error("window read did not return pointed data");

    a_data_we_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        dmem_we_o |=> !dmem_we_o)
        else $error("data write pulse longer than one cycle");

    a_window_write_data: assert property (@(posedge clk_i) disable iff (rst_i)
        dmem_we_o |-> dmem_wdata_o == $past(wb_dat_i[LOW_W-1:0]))
        else $error("window write data wrong");

endmodule : pcsi_pc_sequencer

// ### verilog/pcsi_pkg.sv
package pcsi_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int LATCH_W = 5;
    localparam int JUMP_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int DADDR_W = 9;
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam int WB_SEL_W = 4;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [WB_ADR_W-1:0] OFF_PC_LOW = 8'h00;
    localparam logic [WB_ADR_W-1:0] OFF_UPPER_LATCH = 8'h04;
    localparam logic [WB_ADR_W-1:0] OFF_POINTER = 8'h08;
    localparam logic [WB_ADR_W-1:0] OFF_STATUS = 8'h0c;
    localparam logic [WB_ADR_W-1:0] OFF_WINDOW = 8'h10;
    localparam logic [WB_ADR_W-1:0] OFF_PC_VIEW = 8'h14;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int STATUS_BANK_BIT = 7;
    localparam int STATUS_PAGE_BIT = 6;
    localparam int LATCH_PAGE_HI = 4;
    localparam int LATCH_PAGE_LO = 3;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [LOW_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [LOW_W-1:0] WINDOW_FILE_ADDR = 8'h00;
    localparam logic [LOW_W-1:0] WINDOW_SELF_READ = 8'h00;
    localparam logic [STACK_PTR_W-1:0] PTR_RESET = 3'h0;
    localparam logic [STACK_PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [WB_DAT_W-1:0] WORD_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Sequencing commands from the instruction decoder
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PCSI_OP_NONE = 3'b000,
        PCSI_OP_STEP = 3'b001,
        PCSI_OP_JUMP = 3'b010,
        PCSI_OP_CALL = 3'b011,
        PCSI_OP_RET = 3'b100,
        PCSI_OP_IRQ = 3'b101,
        PCSI_OP_ADD_LOW = 3'b110
    } pcsi_op_e;

    typedef struct packed {
        pcsi_op_e kind;
        logic [JUMP_W-1:0] operand;
        logic [LOW_W-1:0] addend;
    } pcsi_core_op_s;

    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic we;
        logic [LOW_W-1:0] wdata;
    } pcsi_dmem_req_s;

endpackage : pcsi_pkg

// ### verilog/pcsi_ret_stack.sv
`timescale 1ns/1ps

module pcsi_ret_stack
    import pcsi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [PC_W-1:0] din_i,
    output logic [PC_W-1:0] top_o
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Pointer is private; wrap is silent, no overflow flag exists
    logic [PC_W-1:0] mem_r [STACK_DEPTH];
    logic [STACK_PTR_W-1:0] ptr_r;
    logic [STACK_PTR_W-1:0] ptr_nxt;
    logic [STACK_PTR_W-1:0] ptr_prev;

    assign ptr_prev = ptr_r - PTR_ONE;
    assign top_o = mem_r[ptr_prev];

    always_comb begin
        ptr_nxt = ptr_r;
        if (push_i) begin
            ptr_nxt = ptr_r + PTR_ONE;
        end else if (pop_i) begin
            ptr_nxt = ptr_prev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_r <= PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // Cleared on reset so a stray pop returns a known value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                mem_r[i] <= PC_RESET;
            end
        end else if (push_i) begin
            mem_r[ptr_r] <= din_i;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_ptr_push_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        push_i |=> ptr_r == $past(ptr_r) + PTR_ONE)
        else $error("stack pointer did not advance modulo eight");

    a_pop_restores_push: assert property (@(posedge clk_i) disable iff (rst_i)
        (push_i && !pop_i) ##1 (pop_i && !push_i) |-> top_o == $past(din_i))
        else $error("pop did not return last pushed value");

endmodule : pcsi_ret_stack

// ### sim/pcsi_dmem_model.sv
`timescale 1ns/1ps

module pcsi_dmem_model
    import pcsi_pkg::*;
(
    input wire logic clk_i,
    input wire logic [DADDR_W-1:0] addr_i,
    input wire logic we_i,
    input wire logic [LOW_W-1:0] wdata_i,
    output logic [LOW_W-1:0] rdata_o
);
    // ----------------------------------------------------------------
    // Data memory seen by the indirect path
    // ----------------------------------------------------------------
    logic [LOW_W-1:0] mem [0:(1<<DADDR_W)-1];

    // Seeded from the low address byte so a wrong pointer reads a different byte; both banks hold the same pattern
    initial begin
        for (int i = 0; i < (1<<DADDR_W); i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end

    assign rdata_o = mem[addr_i];

    always @(posedge clk_i) begin
        if (we_i === 1'b1) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule : pcsi_dmem_model

// ### sim/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import pcsi_pkg::*;
;
    logic clk_i, rst_i, cyc, stb, we, ack, dwe;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] wdat, rdat, rv;
    pcsi_core_op_s core_op;
    logic [PC_W-1:0] pc, q;
    logic [PC_W-1:0] pushed [0:9];
    logic [DADDR_W-1:0] daddr;
    logic [LOW_W-1:0] dwdata, drdata, m0;
    int n_errors, checks, n_wr, w0;

    pcsi_pc_sequencer i_pcsi_pc_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .core_op_i(core_op), .pc_o(pc), .dmem_addr_o(daddr), .dmem_we_o(dwe), .dmem_wdata_o(dwdata),
        .dmem_rdata_i(drdata));
    pcsi_dmem_model i_pcsi_dmem_model (.clk_i(clk_i), .addr_i(daddr), .we_i(dwe), .wdata_i(dwdata),
        .rdata_o(drdata));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (dwe === 1'b1) n_wr <= n_wr + 1;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Waits for ack without assuming the latency
    task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a, input logic [WB_DAT_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic op(input pcsi_op_e k, input logic [JUMP_W-1:0] x, input logic [LOW_W-1:0] ad);
        @(posedge clk_i);
        core_op <= '{kind: k, operand: x, addend: ad};
        @(posedge clk_i);
        core_op <= '{kind: PCSI_OP_NONE, operand: 11'h000, addend: 8'h00};
        #1;
    endtask : op

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_load();
        wb(1'b1, OFF_UPPER_LATCH, 32'h15);
        wb(1'b1, OFF_PC_LOW, 32'hab);
        #1 chk("pc after low write", 32'h15ab, 32'(pc));
        wb(1'b0, OFF_PC_LOW, 32'h0);
        chk("low byte read", 32'hab, rv);
        wb(1'b1, OFF_PC_VIEW, 32'h0);
        #1 chk("pc after view write", 32'h15ab, 32'(pc));
        wb(1'b0, OFF_PC_VIEW, 32'h0);
        chk("pc view hides upper bits", 32'hab, rv);
        op(PCSI_OP_JUMP, 11'h7ff, 8'h00);
        chk("pc after jump", 32'h17ff, 32'(pc));
        wb(1'b1, OFF_PC_LOW, 32'hff);
        op(PCSI_OP_ADD_LOW, 11'h000, 8'h01);
        chk("pc after add wrap", 32'h1500, 32'(pc));
        op(PCSI_OP_ADD_LOW, 11'h000, 8'h83);
        chk("pc after add", 32'h1583, 32'(pc));
        wb(1'b0, 8'h80, 32'h0);
        chk("unmapped read", 32'h0, rv);
    endtask : t_load

    task automatic t_stack();
        wb(1'b1, OFF_UPPER_LATCH, 32'h18);
        #1 pushed[0] = pc + PC_ONE;
        for (int k = 0; k < 10; k++) begin
            op(PCSI_OP_CALL, 11'h100 + 11'(k), 8'h00);
            chk("pc after call", 32'({2'b11, 11'h100 + 11'(k)}), 32'(pc));
            if (k < 9) pushed[k + 1] = pc + PC_ONE;
        end
        // Ten pushes wrap the eight slots; the ninth pop wraps back again
        for (int j = 0; j < 9; j++) begin
            op(PCSI_OP_RET, 11'h000, 8'h00);
            chk("pc after return", 32'(pushed[9 - (j % 8)]), 32'(pc));
        end
        q = pc;
        op(PCSI_OP_IRQ, 11'h000, 8'h00);
        chk("pc after irq", 32'h0004, 32'(pc));
        op(PCSI_OP_STEP, 11'h000, 8'h00);
        op(PCSI_OP_RET, 11'h000, 8'h00);
        chk("pc after irq return", 32'(q), 32'(pc));
        // Call and return on adjacent cycles
        q = pc;
        @(posedge clk_i);
        core_op <= '{kind: PCSI_OP_CALL, operand: 11'h2aa, addend: 8'h00};
        @(posedge clk_i);
        core_op <= '{kind: PCSI_OP_RET, operand: 11'h000, addend: 8'h00};
        @(posedge clk_i);
        core_op <= '{kind: PCSI_OP_NONE, operand: 11'h000, addend: 8'h00};
        #1 chk("pc after call then return", 32'(q + PC_ONE), 32'(pc));
        wb(1'b0, OFF_UPPER_LATCH, 32'h0);
        chk("latch after stack use", 32'h18, rv);
    endtask : t_stack

    task automatic t_indirect();
        wb(1'b1, OFF_STATUS, 32'h0);
        wb(1'b1, OFF_POINTER, 32'h40);
        wb(1'b1, OFF_WINDOW, 32'h3c);
        repeat (2) @(posedge clk_i);
        chk("data addr", 32'h040, 32'(daddr));
        chk("stored byte", 32'h3c, 32'(i_pcsi_dmem_model.mem[9'h040]));
        wb(1'b0, OFF_WINDOW, 32'h0);
        chk("window read", 32'h3c, rv);
        wb(1'b1, OFF_POINTER, 32'h41);
        wb(1'b0, OFF_WINDOW, 32'h0);
        chk("window read next", 32'h41 ^ 32'ha5, rv);
        wb(1'b1, OFF_POINTER, 32'h00);
        w0 = n_wr;
        m0 = i_pcsi_dmem_model.mem[9'h000];
        wb(1'b1, OFF_WINDOW, 32'h77);
        repeat (2) @(posedge clk_i);
        chk("self write pulses", 32'(w0), 32'(n_wr));
        chk("self write byte", 32'(m0), 32'(i_pcsi_dmem_model.mem[9'h000]));
        wb(1'b0, OFF_WINDOW, 32'h0);
        chk("self read", 32'h0, rv);
    endtask : t_indirect

    task automatic t_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk("pc after reset", 32'h0, 32'(pc));
        wb(1'b0, OFF_UPPER_LATCH, 32'h0);
        chk("latch after reset", 32'h0, rv);
    endtask : t_reset

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h1;
        wdat = 32'h0000_0000;
        core_op = '{kind: PCSI_OP_NONE, operand: 11'h000, addend: 8'h00};
        n_errors = 0;
        checks = 0;
        n_wr = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk("pc after first reset", 32'h0, 32'(pc));
        t_load();
        t_stack();
        t_indirect();
        t_reset();
        conclude();
    end

    // Whole run is about 140 cycles of 8 ns; this allows a wide margin
    initial begin
        #400000;
        n_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        conclude();
    end
endmodule : tb_top
